// file: verilog/floppy_status_defs.svh
// Functional notes
// R1 - Result byte one encodes outcome code
// R2 - Result bytes carry status zero, one, two
// R3 - Status zero top bits classify termination
// R4 - Seek done flag after finished seek
// R5 - Equipment fault: drive fault or 77 steps
// R6 - Not ready or side one on single-sided
// R7 - Capture head and unit at interrupt
// R8 - Flag sector past end of cylinder
// R9 - Unused status bits always read zero
// R10 - Flag CRC failure in ID or data
// R11 - Host slow servicing byte flags overrun
// R12 - Flag sector not found or bad ID
// R13 - Flag write attempt on protected medium
// R14 - Flag missing address mark cases
// R15 - Flag deleted data mark met
// R16 - Flag CRC failure in data field
// R17 - Flag wrong or bad cylinder number
// R18 - Scan equal hit and scan unmet flags
// R19 - Flag missing data mark in field
// R20 - Status three shows live drive inputs
// R21 - Status three shows select outputs driven
// R22 - Status holds until next command; reads harmless
`ifndef FLOPPY_STATUS_DEFS_SVH
`define FLOPPY_STATUS_DEFS_SVH

`define ADDR_W 5
`define OFS_RESULT 5'h00
`define OFS_RESULT5 5'h04
`define OFS_TERM 5'h08
`define OFS_XFER 5'h0c
`define OFS_FIELD 5'h10
`define OFS_DRIVE 5'h14
`define OFS_CTRL 5'h18
`define OFS_LIMIT 5'h1c

`define RC_OK 8'h00
`define RC_GENERAL 8'h01
`define RC_UNSUPPORTED 8'h02
`define RC_ABSENT 8'h03
`define RC_INVALID 8'h04
`define RC_XFER 8'h05
`define RC_CTRL 8'h06
`define RC_BUSY 8'hff

`define TC_NORMAL 2'h0
`define TC_ABNORMAL 2'h1
`define TC_INVALID 2'h2
`define TC_READY_LOST 2'h3

`define STEP_LIMIT 7'h4d
`define INDEX_LIMIT 2'h2
`define BAD_CYL 8'hff
`define LIMIT_RESET 16'h0040
`define CTRL_RESET 2'h3
`define CTRL_PRESENT 0
`define CTRL_SUPPORTED 1

`endif

// file: verilog/floppy_status_pkg.sv
package floppy_status_pkg;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b01,
        MODE_RUN = 2'b10
    } mode_t;

    typedef enum logic [3:0] {
        CMD_READ_DATA = 4'h0,
        CMD_WRITE_DATA = 4'h1,
        CMD_WRITE_DELETED = 4'h2,
        CMD_FORMAT = 4'h3,
        CMD_SCAN = 4'h4,
        CMD_READ_ID = 4'h5,
        CMD_SEEK = 4'h6,
        CMD_RECALIBRATE = 4'h7,
        CMD_OTHER = 4'h8,
        CMD_INVALID = 4'hf
    } cmd_kind_t;

    typedef struct packed {
        mode_t mode;
        cmd_kind_t kind;
        logic [1:0] termination_code;
        logic seek_done;
        logic equipment_fault;
        logic drive_not_ready;
        logic head_side;
        logic drive_unit_bit1;
        logic drive_unit_bit0;
        logic end_of_cylinder;
        logic id_or_data_crc_fault;
        logic overrun;
        logic sector_not_located;
        logic write_protected_refusal;
        logic missing_address_flag;
        logic deleted_mark_seen;
        logic data_field_crc_fault;
        logic wrong_track_id;
        logic scan_match;
        logic scan_unmet;
        logic bad_track_id;
        logic absent_data_mark;
        logic scan_any_hit;
        logic [6:0] steps;
        logic [1:0] index_count;
        logic service_pending;
        logic [15:0] service_count;
        logic [15:0] service_limit;
        logic [1:0] ctrl;
        logic ack;
        logic [31:0] rdata;
    } state_t;

endpackage : floppy_status_pkg

// file: verilog/floppy_status_reporting.sv
`timescale 1ns/100ps
`include "floppy_status_defs.svh"

module floppy_status_reporting
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Command engine events
    input wire logic cmd_start,
    input wire logic [3:0] cmd_kind,
    input wire logic cmd_end,
    input wire logic step_pulse,
    input wire logic index_pulse,
    input wire logic id_mark_found,
    input wire logic sector_past_end,
    input wire logic id_crc_error,
    input wire logic data_crc_error,
    input wire logic sector_missing,
    input wire logic data_mark_missing,
    input wire logic deleted_mark_met,
    input wire logic cyl_valid,
    input wire logic [7:0] cyl_read,
    input wire logic [7:0] target_id_store,
    input wire logic scan_equal,
    input wire logic scan_last_sector,
    input wire logic xfer_request,
    input wire logic xfer_serviced,
    // Drive side
    input wire logic drive_fault_state,
    input wire logic write_protect_state,
    input wire logic drive_ready_state,
    input wire logic track_zero_state,
    input wire logic double_sided_state,
    input wire logic side_select,
    input wire logic [1:0] unit_select,
    // Status
    output logic busy,
    output logic [7:0] result_code
);

    //****************************************
    // Helpers
    //****************************************
    function automatic logic is_rw(input logic [3:0] k);
        is_rw = (k == floppy_status_pkg::CMD_READ_DATA) || (k == floppy_status_pkg::CMD_WRITE_DATA)
            || (k == floppy_status_pkg::CMD_WRITE_DELETED) || (k == floppy_status_pkg::CMD_FORMAT)
            || (k == floppy_status_pkg::CMD_SCAN) || (k == floppy_status_pkg::CMD_READ_ID);
    endfunction : is_rw

    function automatic logic is_write(input logic [3:0] k);
        is_write = (k == floppy_status_pkg::CMD_WRITE_DATA) || (k == floppy_status_pkg::CMD_WRITE_DELETED)
            || (k == floppy_status_pkg::CMD_FORMAT);
    endfunction : is_write

    floppy_status_pkg::state_t st;
    floppy_status_pkg::state_t next_st;
    logic [7:0] term_val;
    logic [7:0] xfer_val;
    logic [7:0] field_val;
    logic [7:0] drive_val;
    logic running;
    logic any_error;
    logic [31:0] read_val;

    //****************************************
    // Register views
    //****************************************
    assign term_val = {st.termination_code, st.seek_done, st.equipment_fault, st.drive_not_ready,
        st.head_side, st.drive_unit_bit1, st.drive_unit_bit0}; // R3 R7
    assign xfer_val = {st.end_of_cylinder, 1'b0, st.id_or_data_crc_fault, st.overrun,
        1'b0, st.sector_not_located, st.write_protected_refusal, st.missing_address_flag}; // R9
    assign field_val = {1'b0, st.deleted_mark_seen, st.data_field_crc_fault, st.wrong_track_id,
        st.scan_match, st.scan_unmet, st.bad_track_id, st.absent_data_mark}; // R9
    assign drive_val = {drive_fault_state, write_protect_state, drive_ready_state, track_zero_state,
        double_sided_state, side_select, unit_select}; // R20 R21
    assign running = (st.mode == floppy_status_pkg::MODE_RUN);
    assign busy = running;
    assign any_error = st.equipment_fault | st.drive_not_ready | st.end_of_cylinder
        | st.id_or_data_crc_fault | st.overrun | st.sector_not_located | st.write_protected_refusal
        | st.missing_address_flag | st.data_field_crc_fault | st.wrong_track_id | st.scan_unmet
        | st.absent_data_mark;

    //****************************************
    // Result code
    //****************************************
    always_comb
    begin
        if (!st.ctrl[`CTRL_PRESENT])
            result_code = `RC_ABSENT; // R1
        else if (!st.ctrl[`CTRL_SUPPORTED])
            result_code = `RC_UNSUPPORTED; // R1
        else if (running)
            result_code = `RC_BUSY; // R1
        else if (st.termination_code == `TC_INVALID)
            result_code = `RC_INVALID; // R1
        else if (st.termination_code == `TC_READY_LOST)
            result_code = `RC_GENERAL; // R1
        else if (st.overrun)
            result_code = `RC_XFER; // R1
        else if (st.termination_code == `TC_ABNORMAL)
            result_code = `RC_CTRL; // R1
        else
            result_code = `RC_OK; // R1
    end

    always_comb
    begin
        case (avs_address)
            `OFS_RESULT: read_val = {field_val, xfer_val, term_val, result_code}; // R2
            `OFS_RESULT5: read_val = 32'h0000_0000; // R2
            `OFS_TERM: read_val = {24'h00_0000, term_val};
            `OFS_XFER: read_val = {24'h00_0000, xfer_val};
            `OFS_FIELD: read_val = {24'h00_0000, field_val};
            `OFS_DRIVE: read_val = {24'h00_0000, drive_val};
            `OFS_CTRL: read_val = {30'h0000_0000, st.ctrl};
            `OFS_LIMIT: read_val = {16'h0000, st.service_limit};
            default: read_val = 32'h0000_0000;
        endcase
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
    assign avs_readdata = st.rdata;

    //****************************************
    // Next state
    //****************************************
    always_comb
    begin
        next_st = st;
        // Bus: one wait cycle, reads have no side effect
        next_st.ack = (avs_read | avs_write) & ~st.ack;
        if (avs_read && !st.ack)
            next_st.rdata = read_val; // R22
        if (avs_write && st.ack && avs_address == `OFS_CTRL)
            next_st.ctrl = avs_writedata[1:0];
        if (avs_write && st.ack && avs_address == `OFS_LIMIT)
            next_st.service_limit = avs_writedata[15:0];

        case (st.mode)
            floppy_status_pkg::MODE_IDLE:
            begin
                if (cmd_start)
                begin
                    // Flags clear only when a new command begins
                    next_st.kind = floppy_status_pkg::cmd_kind_t'(cmd_kind); // R22
                    next_st.termination_code = `TC_NORMAL;
                    next_st.seek_done = 1'b0;
                    next_st.equipment_fault = 1'b0;
                    next_st.end_of_cylinder = 1'b0;
                    next_st.id_or_data_crc_fault = 1'b0;
                    next_st.overrun = 1'b0;
                    next_st.sector_not_located = 1'b0;
                    next_st.write_protected_refusal = 1'b0;
                    next_st.missing_address_flag = 1'b0;
                    next_st.deleted_mark_seen = 1'b0;
                    next_st.data_field_crc_fault = 1'b0;
                    next_st.wrong_track_id = 1'b0;
                    next_st.scan_match = 1'b0;
                    next_st.scan_unmet = 1'b0;
                    next_st.bad_track_id = 1'b0;
                    next_st.absent_data_mark = 1'b0;
                    next_st.scan_any_hit = 1'b0;
                    next_st.steps = 7'h00;
                    next_st.index_count = 2'h0;
                    next_st.service_pending = 1'b0;
                    next_st.service_count = 16'h0000;
                    next_st.drive_not_ready = is_rw(cmd_kind)
                        && (!drive_ready_state || (side_select && !double_sided_state)); // R6
                    next_st.head_side = side_select;
                    next_st.drive_unit_bit1 = unit_select[1];
                    next_st.drive_unit_bit0 = unit_select[0];
                    if (cmd_kind == floppy_status_pkg::CMD_INVALID)
                        next_st.termination_code = `TC_INVALID; // R3
                    else if (next_st.drive_not_ready)
                        next_st.termination_code = `TC_ABNORMAL; // R3 R6
                    else
                        next_st.mode = floppy_status_pkg::MODE_RUN;
                end
            end
            floppy_status_pkg::MODE_RUN:
            begin
                if (drive_fault_state)
                    next_st.equipment_fault = 1'b1; // R5
                if (st.kind == floppy_status_pkg::CMD_RECALIBRATE && step_pulse && !track_zero_state)
                begin
                    next_st.steps = st.steps + 7'h01;
                    if (st.steps + 7'h01 == `STEP_LIMIT)
                        next_st.equipment_fault = 1'b1; // R5
                end
                if (sector_past_end)
                    next_st.end_of_cylinder = 1'b1; // R8
                if (id_crc_error || data_crc_error)
                    next_st.id_or_data_crc_fault = 1'b1; // R10
                if (data_crc_error)
                    next_st.data_field_crc_fault = 1'b1; // R16
                if (sector_missing && (st.kind == floppy_status_pkg::CMD_READ_DATA
                    || st.kind == floppy_status_pkg::CMD_WRITE_DELETED || st.kind == floppy_status_pkg::CMD_SCAN))
                    next_st.sector_not_located = 1'b1; // R12
                if (st.kind == floppy_status_pkg::CMD_READ_ID && id_crc_error)
                    next_st.sector_not_located = 1'b1; // R12
                if (is_write(st.kind) && write_protect_state)
                    next_st.write_protected_refusal = 1'b1; // R13
                if (data_mark_missing)
                begin
                    next_st.missing_address_flag = 1'b1; // R14
                    next_st.absent_data_mark = 1'b1; // R19
                end
                // Two index pulses with no identifier mark
                if (id_mark_found)
                    next_st.index_count = 2'h0;
                else if (is_rw(st.kind) && index_pulse && st.index_count != `INDEX_LIMIT)
                begin
                    next_st.index_count = st.index_count + 2'h1;
                    if (st.index_count + 2'h1 == `INDEX_LIMIT)
                        next_st.missing_address_flag = 1'b1; // R14
                end
                if (deleted_mark_met && (st.kind == floppy_status_pkg::CMD_READ_DATA
                    || st.kind == floppy_status_pkg::CMD_SCAN))
                    next_st.deleted_mark_seen = 1'b1; // R15
                if (cyl_valid && cyl_read != target_id_store)
                begin
                    next_st.wrong_track_id = 1'b1; // R17
                    if (cyl_read == `BAD_CYL)
                        next_st.bad_track_id = 1'b1; // R17
                end
                if (st.kind == floppy_status_pkg::CMD_SCAN)
                begin
                    if (scan_equal)
                    begin
                        next_st.scan_match = 1'b1; // R18
                        next_st.scan_any_hit = 1'b1;
                    end
                    if (scan_last_sector && !st.scan_any_hit && !scan_equal)
                        next_st.scan_unmet = 1'b1; // R18
                end
                // Host service window per transfer byte
                if (xfer_serviced)
                begin
                    next_st.service_pending = 1'b0;
                    next_st.service_count = 16'h0000;
                end
                else if (xfer_request || st.service_pending)
                begin
                    next_st.service_pending = 1'b1;
                    next_st.service_count = st.service_count + 16'h0001;
                    if (st.service_count + 16'h0001 >= st.service_limit)
                        next_st.overrun = 1'b1; // R11
                end
                // Ready loss aborts only read and write kinds

                if (!drive_ready_state && is_rw(st.kind))
                begin
                    next_st.termination_code = `TC_READY_LOST; // R3
                    next_st.head_side = side_select; // R7
                    next_st.drive_unit_bit1 = unit_select[1]; // R7
                    next_st.drive_unit_bit0 = unit_select[0]; // R7
                    next_st.mode = floppy_status_pkg::MODE_IDLE;
                end
                else if (cmd_end)
                begin
                    if (st.kind == floppy_status_pkg::CMD_SEEK || st.kind == floppy_status_pkg::CMD_RECALIBRATE)
                        next_st.seek_done = 1'b1; // R4
                    next_st.head_side = side_select; // R7
                    next_st.drive_unit_bit1 = unit_select[1]; // R7
                    next_st.drive_unit_bit0 = unit_select[0]; // R7
                    next_st.termination_code = (any_error || next_st.overrun || next_st.equipment_fault
                        || next_st.missing_address_flag || next_st.sector_not_located
                        || next_st.id_or_data_crc_fault) ? `TC_ABNORMAL : `TC_NORMAL; // R3
                    next_st.mode = floppy_status_pkg::MODE_IDLE;
                end
            end
            default:
                next_st.mode = floppy_status_pkg::MODE_IDLE;
        endcase
    end

    //****************************************
    // State register
    //****************************************
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.mode <= floppy_status_pkg::MODE_IDLE;
            st.kind <= floppy_status_pkg::CMD_OTHER;
            st.service_limit <= `LIMIT_RESET;
            st.ctrl <= `CTRL_RESET;
        end
        else if (ce)
            st <= next_st;
    end

    //****************************************
    // Assertions
    //****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence start_invalid_s;
        ce && !running && cmd_start && cmd_kind == floppy_status_pkg::CMD_INVALID;
    endsequence

    sequence drive_read_s;
        ce && avs_read && !st.ack && avs_address == `OFS_DRIVE;
    endsequence

    busy_code_a: assert property (running && st.ctrl == `CTRL_RESET |-> result_code == `RC_BUSY) // R1
        else $error("busy result code wrong");
    invalid_class_a: assert property (start_invalid_s |=> st.termination_code == `TC_INVALID // R3
        && !running && result_code == `RC_INVALID || !st.ctrl[`CTRL_PRESENT] || !st.ctrl[`CTRL_SUPPORTED])
        else $error("invalid command class wrong");
    step_fault_a: assert property (ce && running && st.kind == floppy_status_pkg::CMD_RECALIBRATE // R5
        && step_pulse && !track_zero_state && st.steps == `STEP_LIMIT - 7'h01 |=> st.equipment_fault)
        else $error("step limit fault missing");
    not_ready_a: assert property (ce && !running && cmd_start && is_rw(cmd_kind) && !drive_ready_state // R6
        |=> st.drive_not_ready && st.termination_code == `TC_ABNORMAL)
        else $error("not ready flag missing");
    zero_bits_a: assert property (xfer_val[6] == 1'b0 && xfer_val[3] == 1'b0 && field_val[7] == 1'b0) // R9
        else $error("reserved status bit set");
    drive_view_a: assert property (drive_read_s ##1 !avs_waitrequest |-> avs_readdata[7:0] == $past(drive_val)) // R20
        else $error("drive status read wrong");
    overrun_a: assert property (ce && running && st.service_pending && !xfer_serviced && !cmd_end // R11
        && drive_ready_state && st.service_count + 16'h0001 >= st.service_limit |=> st.overrun)
        else $error("overrun not flagged");
    bad_cyl_a: assert property (ce && running && cyl_valid && cyl_read == `BAD_CYL // R17
        && target_id_store != `BAD_CYL |=> st.bad_track_id && st.wrong_track_id)
        else $error("bad cylinder not flagged");
    mark_pair_a: assert property (ce && running && data_mark_missing // R14
        |=> st.missing_address_flag && st.absent_data_mark)
        else $error("missing mark pair wrong");
    hold_idle_a: assert property (!running && !(ce && cmd_start) |=> $stable(term_val) // R22
        && $stable(xfer_val) && $stable(field_val))
        else $error("status changed while idle");

endmodule : floppy_status_reporting

// file: tb/floppy_drive_model.sv
`timescale 1ns/100ps
// ****************************************
// Drive head position and track-zero sensor
// ****************************************
module floppy_drive_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic step_pulse,
    input wire logic park_far,
    output logic track_zero_state
);
    logic [7:0] pos;

    // Parking far out puts track zero beyond the reach of one recalibrate
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            pos <= 8'h03;
        else if (park_far)
            pos <= 8'hc8;
        else if (step_pulse && pos != 8'h00)
            pos <= pos - 8'h01;
    end

    assign track_zero_state = (pos == 8'h00);
endmodule : floppy_drive_model

// file: tb/floppy_status_reporting_tb.sv
`timescale 1ns/100ps
module floppy_status_reporting_tb;
    localparam logic [31:0] all_bits = 32'hffffffff;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cmd_start = 1'h0;
    logic [3:0] cmd_kind = 4'h0;
    logic cmd_end = 1'h0;
    logic [13:0] ev = 14'h0;
    logic [7:0] cyl_read = 8'hff;
    logic fault = 1'h0;
    logic protect = 1'h0;
    logic ready = 1'h1;
    logic two_side = 1'h1;
    logic park = 1'h0;
    logic side_select = 1'h1;
    logic [1:0] unit_select = 2'h2;
    logic t0;
    logic busy;
    logic [7:0] result_code;
    logic [31:0] q;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    always #4 sys_clk = ~sys_clk;

    floppy_drive_model drive (.sys_clk(sys_clk), .rst_n(rst_n), .step_pulse(ev[0]), .park_far(park),
        .track_zero_state(t0));

    floppy_status_reporting DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'h1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_end(cmd_end),
        .step_pulse(ev[0]), .index_pulse(ev[1]), .id_mark_found(ev[2]), .sector_past_end(ev[3]),
        .id_crc_error(ev[4]), .data_crc_error(ev[5]), .sector_missing(ev[6]), .data_mark_missing(ev[7]),
        .deleted_mark_met(ev[8]), .cyl_valid(ev[13]), .cyl_read(cyl_read), .target_id_store(8'h05),
        .scan_equal(ev[9]), .scan_last_sector(ev[10]), .xfer_request(ev[11]), .xfer_serviced(ev[12]),
        .drive_fault_state(fault), .write_protect_state(protect), .drive_ready_state(ready),
        .track_zero_state(t0), .double_sided_state(two_side), .side_select(side_select),
        .unit_select(unit_select), .busy(busy), .result_code(result_code));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'h0)
            @(posedge sys_clk);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge sys_clk);
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
        bus(1'h0, a, 32'h0);
        check(what, q & mask, exp);
    endtask : rd

    task automatic rc(input logic [7:0] e);
        check("result_code", {24'h0, result_code}, {24'h0, e});
    endtask : rc

    task automatic run(input logic [3:0] k, input logic [13:0] e, input int steps, input logic fin);
        cmd_kind <= k;
        cmd_start <= 1'h1;
        @(posedge sys_clk);
        cmd_start <= 1'h0;
        ev <= e;
        @(posedge sys_clk);
        ev <= 14'h0;
        repeat (steps)
        begin
            @(posedge sys_clk);
            ev <= (e == 14'h0) ? 14'h1 : e;
            @(posedge sys_clk);
            ev <= 14'h0;
        end
        repeat (10) @(posedge sys_clk);
        cmd_end <= fin;
        @(posedge sys_clk);
        cmd_end <= 1'h0;
        repeat (2) @(posedge sys_clk);
    endtask : run

    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        int k;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'h1;
        @(posedge sys_clk);
        rd(5'h18, all_bits, 32'h3, "ctrl");
        rd(5'h1c, all_bits, 32'h40, "limit");
        rd(5'h00, all_bits, 32'h0, "result_word");
        run(4'h0, 14'h20, 0, 1'h1);
        rd(5'h00, all_bits, 32'h20204606, "result_word");
        rd(5'h0c, all_bits, 32'h20, "xfer_status");
        bus(1'h1, 5'h08, 32'hff);
        rd(5'h08, all_bits, 32'h46, "term_status");
        rd(5'h04, all_bits, 32'h0, "byte5");
        run(4'h0, 14'h20c8, 0, 1'h1);
        rd(5'h0c, all_bits, 32'h85, "xfer_status");
        rd(5'h10, all_bits, 32'h13, "field_status");
        cyl_read <= 8'h06;
        run(4'h4, 14'h2300, 0, 1'h1);
        rd(5'h10, all_bits, 32'h58, "field_status");
        run(4'h4, 14'h400, 0, 1'h1);
        rd(5'h10, 32'h0c, 32'h04, "field_status");
        run(4'h5, 14'h12, 1, 1'h1);
        rd(5'h0c, all_bits, 32'h25, "xfer_status");
        protect <= 1'h1;
        for (k = 1; k < 4; k++)
        begin
            run(k[3:0], 14'h0, 0, 1'h1);
            rd(5'h0c, 32'h02, 32'h02, "xfer_status");
        end
        protect <= 1'h0;
        bus(1'h1, 5'h1c, 32'h4);
        run(4'h0, 14'h800, 0, 1'h1);
        rd(5'h0c, 32'h10, 32'h10, "xfer_status");
        rc(8'h05);
        run(4'h6, 14'h0, 0, 1'h1);
        rd(5'h08, 32'hf8, 32'h20, "term_status");
        rc(8'h00);
        run(4'h7, 14'h0, 5, 1'h1);
        rd(5'h08, 32'h30, 32'h20, "term_status");
        fault <= 1'h1;
        side_select <= 1'h0;
        unit_select <= 2'h1;
        rd(5'h14, all_bits, 32'hb9, "drive_status");
        run(4'h6, 14'h0, 0, 1'h1);
        rd(5'h08, 32'h10, 32'h10, "term_status");
        fault <= 1'h0;
        side_select <= 1'h1;
        unit_select <= 2'h2;
        park <= 1'h1;
        @(posedge sys_clk);
        park <= 1'h0;
        run(4'h7, 14'h0, 77, 1'h1);
        rd(5'h08, 32'h10, 32'h10, "term_status");
        ready <= 1'h0;
        run(4'h0, 14'h0, 0, 1'h0);
        rd(5'h08, 32'hf8, 32'h48, "term_status");
        rc(8'h06);
        ready <= 1'h1;
        two_side <= 1'h0;
        run(4'h1, 14'h0, 0, 1'h0);
        rd(5'h08, 32'hf8, 32'h48, "term_status");
        two_side <= 1'h1;
        run(4'hf, 14'h0, 0, 1'h0);
        rd(5'h08, 32'hc0, 32'h80, "term_status");
        rc(8'h04);
        run(4'h0, 14'h0, 0, 1'h0);
        rc(8'hff);
        check("busy", {31'h0, busy}, 32'h1);
        ready <= 1'h0;
        repeat (3) @(posedge sys_clk);
        ready <= 1'h1;
        repeat (3) @(posedge sys_clk);
        rd(5'h08, 32'hc0, 32'hc0, "term_status");
        rc(8'h01);
        check("busy", {31'h0, busy}, 32'h0);
        bus(1'h1, 5'h18, 32'h2);
        rc(8'h03);
        bus(1'h1, 5'h18, 32'h1);
        rc(8'h02);
        tally_and_finish();
    end
endmodule : floppy_status_reporting_tb
